// *** src/bcc_bridge_ctrl.sv ***
// Host command interpreter of the two-wire to single-wire bridge.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module bcc_bridge_ctrl (
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n,
   input  wire logic        line_level_in,
   output logic             line_abort,
   output logic             reset_active,
   output logic             speed_select,
   output logic             active_pullup_enable,
   output logic             presence_mask_enable,
   output logic             strong_pullup_enable
);

   // -----------------------------------------------------------------
   // State record
   // -----------------------------------------------------------------
   // All flip-flops live in one record: the next-state process starts from a
   // copy of it, so any field that a branch leaves alone simply holds.
   typedef struct packed {
      logic                scl_m;
      logic                scl_s;
      logic                scl_p;
      logic                sda_m;
      logic                sda_s;
      logic                sda_p;
      logic                lvl_m;
      logic                lvl_s;
      bcc_pkg::bcc_state_type st;
      logic [3:0]          bitcnt;
      logic [7:0]          shreg;
      logic [7:0]          cmd;
      logic                byte_idx;
      logic                rw;
      logic                mack;
      logic                sda_drv;
      bcc_pkg::bcc_ptr_type ptr;
      logic [3:0]          cfg;
      logic [7:0]          status;
      logic [7:0]          rdata;
      logic [2:0]          rcnt;
      logic [31:0]         prdata;
   } bcc_regs_type;

   bcc_regs_type q;
   bcc_regs_type d;
   logic         scl_rise;
   logic         scl_fall;
   logic         start_cond;
   logic         stop_cond;
   logic         fire;
   logic         ack;
   logic         apb_hit;

   // Byte shown to the host for a given pointer position.
   // Configuration reads always show zero in the upper nibble.
   function automatic logic [7:0] rd_sel(input bcc_pkg::bcc_ptr_type p,
                                         input logic [7:0]           st,
                                         input logic [7:0]           rd,
                                         input logic [3:0]           cf);
      logic [7:0] v;
      v = st;
      case (p)
         bcc_pkg::BCC_PTR_STATUS: v = st;
         bcc_pkg::BCC_PTR_RDATA:  v = rd;
         bcc_pkg::BCC_PTR_CONFIG: v = {4'h0, cf};
         default:                 v = st;
      endcase
      return v;
   endfunction : rd_sel

   // -----------------------------------------------------------------
   // Pin events
   // -----------------------------------------------------------------
   // Edges are taken only from the second synchroniser stage and its delayed copy,
   // so a metastable first stage never reaches a decision.
   assign scl_rise   = q.scl_s & ~q.scl_p;
   assign scl_fall   = ~q.scl_s & q.scl_p;
   assign start_cond = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
   assign stop_cond  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

   // Reset fires on the falling edge that ends the acknowledge of an F0h code.
   assign fire = (q.st == bcc_pkg::BCC_WR_ACK) && scl_fall && !q.byte_idx
                 && (q.cmd == bcc_pkg::CMD_DEVICE_RESET) && !start_cond
                 && !stop_cond;

   // -----------------------------------------------------------------
   // Acknowledge decision for the byte just shifted in
   // -----------------------------------------------------------------
   // The decision uses the byte as it stands after the eighth rising edge,
   // so the pull-down can start at the very next falling edge.
   always_comb begin
      ack = 1'b0;
      if (!q.byte_idx) begin
         case (q.shreg)
            bcc_pkg::CMD_DEVICE_RESET: ack = 1'b1;
            bcc_pkg::CMD_SET_POINTER:  ack = 1'b1;
            bcc_pkg::CMD_WRITE_CONFIG: ack = !q.status[bcc_pkg::ST_BUSY];
            default:                   ack = 1'b0;
         endcase
      end else if (q.cmd == bcc_pkg::CMD_SET_POINTER) begin
         ack = (q.shreg == bcc_pkg::PTR_CODE_STATUS) ||
               (q.shreg == bcc_pkg::PTR_CODE_RDATA)  ||
               (q.shreg == bcc_pkg::PTR_CODE_CONFIG);
      end else if (q.cmd == bcc_pkg::CMD_WRITE_CONFIG) begin
         ack = (q.shreg[7:4] == ~q.shreg[3:0]);
      end
   end

   // -----------------------------------------------------------------
   // APB decode
   // -----------------------------------------------------------------
   // The slave never inserts wait states; read data is captured in the
   // setup cycle so that prdata comes straight from a flip-flop.
   always_comb begin
      case (paddr)
         bcc_pkg::REG_STATUS,
         bcc_pkg::REG_CONFIG,
         bcc_pkg::REG_POINTER,
         bcc_pkg::REG_LINE,
         bcc_pkg::REG_RDATA:  apb_hit = 1'b1;
         default:             apb_hit = 1'b0;
      endcase
   end

   // Unmapped addresses answer at once but raise the error flag.
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~apb_hit;

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      d = q;

      // Two-stage synchronisers and one delayed copy for edge finding.
      d.scl_m = scl_in;
      d.scl_s = q.scl_m;
      d.scl_p = q.scl_s;
      d.sda_m = sda_in;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      d.lvl_m = line_level_in;
      d.lvl_s = q.lvl_m;

      // Reset activity counts down from the hold loaded by a device reset.
      if (q.rcnt != 3'h0) begin
         d.rcnt = q.rcnt - 3'h1;
      end

      // APB read capture in the setup cycle.
      if (psel && !penable && !pwrite) begin
         case (paddr)
            bcc_pkg::REG_STATUS:  d.prdata = {24'h0, q.status};
            bcc_pkg::REG_CONFIG:  d.prdata = {28'h0, q.cfg};
            bcc_pkg::REG_POINTER: d.prdata = {30'h0, q.ptr};
            bcc_pkg::REG_LINE:    d.prdata = {24'h0, q.status & bcc_pkg::STATUS_LINE_WR};
            bcc_pkg::REG_RDATA:   d.prdata = {24'h0, q.rdata};
            default:              d.prdata = 32'h0;
         endcase
      end

      // APB writes: the single-wire engine side reports its results here.
      // Settings and the reset flag cannot be written over the register bus.
      if (psel && penable && pwrite) begin
         if (paddr == bcc_pkg::REG_LINE) begin
            d.status = (q.status & ~bcc_pkg::STATUS_LINE_WR)
                     | (pwdata[7:0] & bcc_pkg::STATUS_LINE_WR);
         end else if (paddr == bcc_pkg::REG_RDATA) begin
            d.rdata = pwdata[7:0];
         end
      end

      // Two-wire slave sequencing.
      case (q.st)
         bcc_pkg::BCC_IDLE: begin
            // Bus free: nothing is pulled and nothing is shifted.
            d.sda_drv = 1'b0;
         end
         bcc_pkg::BCC_ADDR: begin
            // Slave address and direction, most significant bit first.
            if (scl_rise) begin
               d.shreg  = {q.shreg[6:0], q.sda_s};
               d.bitcnt = q.bitcnt + 4'h1;
            end else if (scl_fall && q.bitcnt == 4'h8) begin
               if (q.shreg[7:1] == bcc_pkg::I2C_ADDRESS) begin
                  d.rw      = q.shreg[0];
                  d.sda_drv = 1'b1;
                  d.st      = bcc_pkg::BCC_ADDR_ACK;
               end else begin
                  d.st = bcc_pkg::BCC_IGNORE;
               end
            end
         end
         bcc_pkg::BCC_ADDR_ACK: begin
            // The line level is refreshed when a read addresses the status register.
            if (scl_rise && q.rw && q.ptr == bcc_pkg::BCC_PTR_STATUS) begin
               d.status[bcc_pkg::ST_LEVEL] = q.lvl_s;
            end else if (scl_fall) begin
               d.bitcnt   = 4'h0;
               d.byte_idx = 1'b0;
               if (q.rw) begin
                  d.shreg   = rd_sel(q.ptr, q.status, q.rdata, q.cfg);
                  d.sda_drv = ~d.shreg[7];
                  d.st      = bcc_pkg::BCC_RD;
               end else begin
                  d.sda_drv = 1'b0;
                  d.st      = bcc_pkg::BCC_WR;
               end
            end
         end
         bcc_pkg::BCC_WR: begin
            // Command code or parameter byte coming in from the host.
            if (scl_rise) begin
               d.shreg  = {q.shreg[6:0], q.sda_s};
               d.bitcnt = q.bitcnt + 4'h1;
            end else if (scl_fall && q.bitcnt == 4'h8) begin
               if (!q.byte_idx) begin
                  d.cmd = q.shreg;
               end
               // A refused byte is simply not pulled low and the rest is dropped.
               if (ack) begin
                  d.sda_drv = 1'b1;
                  d.st      = bcc_pkg::BCC_WR_ACK;
               end else begin
                  d.st = bcc_pkg::BCC_IGNORE;
               end
            end
         end
         bcc_pkg::BCC_WR_ACK: begin
            // The data line is held low for the whole acknowledge bit.
            if (scl_rise && q.byte_idx) begin
               if (q.cmd == bcc_pkg::CMD_SET_POINTER) begin
                  // Only the pointer moves; status and settings are left alone.
                  case (q.shreg)
                     bcc_pkg::PTR_CODE_RDATA:  d.ptr = bcc_pkg::BCC_PTR_RDATA;
                     bcc_pkg::PTR_CODE_CONFIG: d.ptr = bcc_pkg::BCC_PTR_CONFIG;
                     default:                  d.ptr = bcc_pkg::BCC_PTR_STATUS;
                  endcase
               end else begin
                  // Only a checked byte gets here, so all four settings move together.
                  d.cfg                     = q.shreg[3:0];
                  d.status[bcc_pkg::ST_RST] = 1'b0;
                  d.ptr                     = bcc_pkg::BCC_PTR_CONFIG;
               end
            end else if (scl_fall) begin
               d.sda_drv  = 1'b0;
               d.bitcnt   = 4'h0;
               d.byte_idx = 1'b1;
               if (!q.byte_idx && q.cmd != bcc_pkg::CMD_DEVICE_RESET) begin
                  d.st = bcc_pkg::BCC_WR;
               end else begin
                  d.st = bcc_pkg::BCC_IGNORE;
               end
            end
         end
         bcc_pkg::BCC_RD: begin
            // Bits go out after falling edges so they are settled before the rise.
            if (scl_fall) begin
               d.bitcnt = q.bitcnt + 4'h1;
               if (q.bitcnt == 4'h7) begin
                  d.sda_drv = 1'b0;
                  d.st      = bcc_pkg::BCC_RD_ACK;
               end else begin
                  d.shreg   = {q.shreg[6:0], 1'b0};
                  d.sda_drv = ~q.shreg[6];
               end
            end
         end
         bcc_pkg::BCC_RD_ACK: begin
            // The host's acknowledge decides whether another byte follows.
            if (scl_rise) begin
               d.mack = ~q.sda_s;
            end else if (scl_fall) begin
               d.bitcnt = 4'h0;
               if (q.mack) begin
                  // Further reads return the same register again.
                  d.shreg   = rd_sel(q.ptr, q.status, q.rdata, q.cfg);
                  d.sda_drv = ~d.shreg[7];
                  d.st      = bcc_pkg::BCC_RD;
               end else begin
                  d.st = bcc_pkg::BCC_IGNORE;
               end
            end
         end
         bcc_pkg::BCC_IGNORE: begin
            // Refused or finished transfer: wait quietly for a start or stop.
            d.sda_drv = 1'b0;
         end
         default: begin
            // Unreachable codes fall back to the idle state.
            d.sda_drv = 1'b0;
            d.st      = bcc_pkg::BCC_IDLE;
         end
      endcase

      // Start and stop override any byte in progress.
      if (start_cond) begin
         d.st       = bcc_pkg::BCC_ADDR;
         d.bitcnt   = 4'h0;
         d.byte_idx = 1'b0;
         d.sda_drv  = 1'b0;
      end else if (stop_cond) begin
         d.st      = bcc_pkg::BCC_IDLE;
         d.sda_drv = 1'b0;
      end

      // Device reset is applied last so that it wins over a same-cycle APB write.
      // The line level flag follows the pin, not the logic, so a reset keeps it.
      if (fire) begin
         d.status                    = 8'h00;
         d.status[bcc_pkg::ST_LEVEL] = q.status[bcc_pkg::ST_LEVEL];
         d.status[bcc_pkg::ST_RST]   = 1'b1;
         d.cfg                       = bcc_pkg::CONFIG_RESET;
         d.ptr                       = bcc_pkg::BCC_PTR_STATUS;
         d.rcnt                      = bcc_pkg::RESET_HOLD;
      end
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   // Clock and data synchroniser stages reset to the idle-high bus level, so that no false
   // edge, start or stop is seen as reset is released.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         q        <= '0;
         q.scl_m  <= 1'b1;
         q.scl_s  <= 1'b1;
         q.scl_p  <= 1'b1;
         q.sda_m  <= 1'b1;
         q.sda_s  <= 1'b1;
         q.sda_p  <= 1'b1;
         q.st     <= bcc_pkg::BCC_IDLE;
         q.ptr    <= bcc_pkg::BCC_PTR_STATUS;
         q.cfg    <= bcc_pkg::CONFIG_RESET;
         q.status <= bcc_pkg::STATUS_RESET; // Power-on counts as a reset.
      end else begin
         q <= d;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   // The abort pulse is taken straight from the edge decision: waiting one
   // more register stage would eat most of the allowed abort latency.
   assign line_abort           = fire;
   assign reset_active         = fire | (q.rcnt != 3'h0);
   assign prdata               = q.prdata;
   assign sda_out              = 1'b0;                      // Open drain: only ever pulls low.
   assign sda_oe_n             = ~q.sda_drv;
   // Settings leave the block straight from their flip-flops.
   assign speed_select         = q.cfg[bcc_pkg::CF_SPD];
   assign active_pullup_enable = q.cfg[bcc_pkg::CF_ACTIVE];
   assign presence_mask_enable = q.cfg[bcc_pkg::CF_PMASK];
   assign strong_pullup_enable = q.cfg[bcc_pkg::CF_STRONG];

endmodule : bcc_bridge_ctrl

`default_nettype wire

// *** src/bcc_pkg.sv ***
// Constants and types shared by the bridge control command block.
package bcc_pkg;

   // -----------------------------------------------------------------
   // Command and pointer codes
   // -----------------------------------------------------------------
   localparam logic [7:0] CMD_DEVICE_RESET = 8'hf0;
   localparam logic [7:0] CMD_SET_POINTER  = 8'he1;
   localparam logic [7:0] CMD_WRITE_CONFIG = 8'hd2;
   localparam logic [7:0] PTR_CODE_STATUS  = 8'hf0;
   localparam logic [7:0] PTR_CODE_RDATA   = 8'he1;
   localparam logic [7:0] PTR_CODE_CONFIG  = 8'hc3;
   localparam logic [6:0] I2C_ADDRESS      = 7'h18;

   // -----------------------------------------------------------------
   // Status and configuration bit positions
   // -----------------------------------------------------------------
   localparam int ST_BUSY     = 0;
   localparam int ST_PRESENCE = 1;
   localparam int ST_SHORT    = 2;
   localparam int ST_LEVEL    = 3;
   localparam int ST_RST      = 4;
   localparam int ST_BITRES   = 5;
   localparam int ST_TRIPLET  = 6;
   localparam int ST_DIR      = 7;
   localparam int CF_ACTIVE   = 0;
   localparam int CF_PMASK    = 1;
   localparam int CF_STRONG   = 2;
   localparam int CF_SPD      = 3;
   localparam logic [7:0] STATUS_RESET   = 8'h10;
   localparam logic [7:0] STATUS_LINE_WR = 8'he7;
   localparam logic [3:0] CONFIG_RESET   = 4'h0;

   // -----------------------------------------------------------------
   // APB register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] REG_STATUS  = 8'h00;
   localparam logic [7:0] REG_CONFIG  = 8'h04;
   localparam logic [7:0] REG_POINTER = 8'h08;
   localparam logic [7:0] REG_LINE    = 8'h0c;
   localparam logic [7:0] REG_RDATA   = 8'h10;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 100000;
   localparam int ABORT_MAX_PS  = 262500;
   localparam int RESET_MAX_PS  = 525000;
   localparam int ABORT_CYC     = (ABORT_MAX_PS / CLK_PERIOD_PS < 1) ? 1
                                  : ABORT_MAX_PS / CLK_PERIOD_PS;
   localparam int RESET_CYC     = (RESET_MAX_PS / CLK_PERIOD_PS < 1) ? 1
                                  : RESET_MAX_PS / CLK_PERIOD_PS;
   // The abort may come ABORT_CYC cycles after the pin edge; its own cycle
   // and the hold must still fit inside the whole reset time.
   localparam logic [2:0] RESET_HOLD = 3'(RESET_CYC - ABORT_CYC - 1);

   typedef enum logic [3:0] {
      BCC_IDLE, BCC_ADDR, BCC_ADDR_ACK, BCC_WR, BCC_WR_ACK,
      BCC_RD, BCC_RD_ACK, BCC_IGNORE
   } bcc_state_type;

   typedef enum logic [1:0] {
      BCC_PTR_STATUS, BCC_PTR_RDATA, BCC_PTR_CONFIG
   } bcc_ptr_type;

endpackage : bcc_pkg

// *** testbench/bcc_bridge_ctrl_checker.sv ***
// Concurrent checks on the ports of the bridge control command block.
`timescale 1ns/10ps
`default_nettype none

module bcc_bridge_ctrl_checker (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic scl_in,
   input wire logic sda_oe_n,
   input wire logic line_abort,
   input wire logic reset_active,
   input wire logic speed_select,
   input wire logic active_pullup_enable,
   input wire logic presence_mask_enable,
   input wire logic strong_pullup_enable
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   // The four settings seen as one value, in configuration bit order.
   logic [3:0] cfg;
   assign cfg = {speed_select, strong_pullup_enable, presence_mask_enable,
                 active_pullup_enable};

   property p_abort_pulse; line_abort |=> !line_abort; endproperty
   a_abort_pulse: assert property (p_abort_pulse)
      else $error("abort pulse longer than one cycle");
   property p_abort_rst; line_abort |-> reset_active; endproperty
   a_abort_rst: assert property (p_abort_rst)
      else $error("abort without reset activity");
   property p_rst_len; $rose(reset_active) |-> reset_active[*3] ##1 !reset_active; endproperty
   a_rst_len: assert property (p_rst_len)
      else $error("reset activity length wrong");
   property p_rst_cause; $rose(reset_active) |-> line_abort; endproperty
   a_rst_cause: assert property (p_rst_cause)
      else $error("reset activity without abort");
   property p_cfg_clear; line_abort |=> cfg == 4'h0; endproperty
   a_cfg_clear: assert property (p_cfg_clear)
      else $error("settings not cleared by reset");
   // Settings move only at an acknowledge the device holds, or just after a reset.
   property p_cfg_ack; $changed(cfg) |-> !sda_oe_n || $past(line_abort) || reset_active;
   endproperty
   a_cfg_ack: assert property (p_cfg_ack)
      else $error("settings changed outside an acknowledge");
   property p_abort_scl; line_abort |-> !scl_in && !$past(scl_in); endproperty
   a_abort_scl: assert property (p_abort_scl)
      else $error("abort not after a falling clock");
   // Driving and releasing the data pin while the clock is high would fake start or stop.
   property p_drive_low; $changed(sda_oe_n) |-> !scl_in; endproperty
   a_drive_low: assert property (p_drive_low)
      else $error("data pin changed while clock high");

   c_abort: cover property (line_abort);
   c_ack: cover property ($fell(sda_oe_n));
   c_cfg: cover property ($rose(speed_select));
endmodule : bcc_bridge_ctrl_checker

bind bcc_bridge_ctrl bcc_bridge_ctrl_checker bcc_bridge_ctrl_checker_inst (.clk_sys, .arst_n,
   .scl_in, .sda_oe_n, .line_abort, .reset_active, .speed_select, .active_pullup_enable,
   .presence_mask_enable, .strong_pullup_enable);

`default_nettype wire

// *** testbench/bcc_i2c_host.sv ***
// Two-wire host model that sends commands to the bridge and reads bytes back.
`timescale 1ns/10ps
`default_nettype none

module bcc_i2c_host (
   output logic     scl,
   output logic     sda_low,
   input wire logic sda
);
   // Idle bus: the clock stands high and data is left to the pull-up.
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // One bit; the low phase is long enough for the device to set up its bit.
   task automatic bit_io(input logic b, output logic got);
      scl = 1'b0;
      #300 sda_low = ~b;
      #300 scl = 1'b1;
      #150 got = sda;
      #50;
   endtask : bit_io

   task automatic start();
      #13 sda_low = 1'b1;
      #300 scl = 1'b0;
   endtask : start

   task automatic stop();
      scl = 1'b0;
      #300 sda_low = 1'b1;
      #300 scl = 1'b1;
      #300 sda_low = 1'b0;
      #300;
   endtask : stop

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic g;
      for (int i = 7; i >= 0; i--) bit_io(d[i], g);
      bit_io(1'b1, g);
      ack = ~g;
   endtask : put_byte

   // Address, code and optional parameter; acks returned address first.
   task automatic command(input logic [7:0] c, p, input logic h, output logic [2:0] acks);
      start();
      put_byte({bcc_pkg::I2C_ADDRESS, 1'b0}, acks[2]);
      put_byte(c, acks[1]);
      acks[0] = 1'b0;
      if (h) put_byte(p, acks[0]);
      stop();
   endtask : command

   // One byte read, ended by the host's refusal so the device lets go.
   task automatic read1(output logic [7:0] d, output logic ack);
      logic g;
      start();
      put_byte({bcc_pkg::I2C_ADDRESS, 1'b1}, ack);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(1'b1, g);
      stop();
   endtask : read1
endmodule : bcc_i2c_host

`default_nettype wire

// *** testbench/bcc_bridge_ctrl_bench.sv ***
// Self-checking bench of the bridge control command block.
`timescale 1ns/10ps
`default_nettype none

module bcc_bridge_ctrl_bench;
   logic        clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, err, ra;
   logic        scl, sda_low, sda, sda_out, sda_oe_n, line_level_in, line_abort, reset_active;
   wire  [3:0]  cfg;
   logic [2:0]  acks;
   logic [7:0]  paddr, v;
   logic [31:0] pwdata, prdata;
   int          num_errors, tests_run, aborts;
   logic [3:0]  cv [3] = '{4'h5, 4'ha, 4'hf};
   logic [7:0]  codes [3] = '{8'hf0, 8'he1, 8'hc3};
   logic [7:0]  pexp [3] = '{8'h08, 8'h3c, 8'h0f};

   bcc_bridge_ctrl bcc_bridge_ctrl_inst (.clk_sys, .arst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe_n,
      .line_level_in, .line_abort, .reset_active, .speed_select(cfg[3]),
      .active_pullup_enable(cfg[0]), .presence_mask_enable(cfg[1]),
      .strong_pullup_enable(cfg[2]));
   bcc_i2c_host bcc_i2c_host_inst (.scl, .sda_low, .sda);

   // Open-drain data wire with pull-up: low when either side pulls.
   assign sda = (sda_oe_n | sda_out) & ~sda_low;

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // Abort pulses are counted so a missing or doubled one shows up.
   always @(posedge clk_sys) if (line_abort === 1'b1) aborts <= aborts + 1;

   task automatic chk_val(input string n, input logic [7:0] e, g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk_val

   task automatic chk_acks(input string n, input logic [2:0] e);
      tests_run++;
      if (acks !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, acks);
      end
   endtask : chk_acks

   // One transfer; an edge passes first so psel is never set twice in a step.
   task automatic apb(input logic w, input logic [7:0] a, d);
      @(posedge clk_sys);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      v = prdata[7:0];
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, e, m, input string n);
      apb(1'b0, a, 8'h00);
      chk_val(n, e & m, v & m);
   endtask : rd

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out

   initial begin
      #2_000_000;
      num_errors++;
      close_out();
   end

   // Map: 00 status, 04 config, 08 pointer, 0c line flags, 10 read data.
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      line_level_in = 1'b1;
      arst_n = 1'b0;
      repeat (12) @(posedge clk_sys);
      arst_n <= 1'b1;
      rd(8'h00, 8'h10, 8'hf7, "status");
      rd(8'h14, 8'h00, 8'hff, "unmapped data");
      chk_val("unmapped error", 8'h01, {7'h0, err});
      $display("test power-up done");
      for (int i = 0; i < 3; i++) begin
         bcc_i2c_host_inst.command(8'hd2, {~cv[i], cv[i]}, 1'b1, acks);
         chk_acks("config acks", 3'b111);
         chk_val("settings", {4'h0, cv[i]}, {4'h0, cfg});
         rd(8'h00, 8'h00, 8'h10, "reset flag");
         rd(8'h08, 8'h02, 8'hff, "pointer");
         bcc_i2c_host_inst.read1(v, ra);
         chk_val("config read", {4'h0, cv[i]}, v);
      end
      bcc_i2c_host_inst.command(8'hd2, 8'h55, 1'b1, acks);
      chk_acks("bad nibble acks", 3'b110);
      rd(8'h04, 8'h0f, 8'hff, "config kept");
      $display("test config done");
      apb(1'b1, 8'h10, 8'h3c);
      for (int i = 0; i < 3; i++) begin
         bcc_i2c_host_inst.command(8'he1, codes[i], 1'b1, acks);
         chk_acks("pointer acks", 3'b111);
         rd(8'h08, 8'(i), 8'hff, "pointer");
         bcc_i2c_host_inst.read1(v, ra);
         chk_val("pointed read", pexp[i], v);
      end
      rd(8'h04, 8'h0f, 8'hff, "config after pointer");
      bcc_i2c_host_inst.command(8'he1, 8'hb4, 1'b1, acks);
      chk_acks("bad pointer acks", 3'b110);
      bcc_i2c_host_inst.command(8'h87, 8'h00, 1'b0, acks);
      chk_acks("unknown acks", 3'b100);
      rd(8'h08, 8'h02, 8'hff, "pointer kept");
      $display("test pointer done");
      apb(1'b1, 8'h0c, bcc_pkg::STATUS_LINE_WR);
      bcc_i2c_host_inst.command(8'hd2, 8'hf0, 1'b1, acks);
      chk_acks("busy config acks", 3'b100);
      rd(8'h04, 8'h0f, 8'hff, "config busy");
      bcc_i2c_host_inst.command(8'he1, 8'hf0, 1'b1, acks);
      bcc_i2c_host_inst.command(8'he1, 8'hc3, 1'b1, acks);
      chk_acks("busy pointer acks", 3'b111);
      rd(8'h00, 8'he7, 8'hf7, "status busy");
      bcc_i2c_host_inst.command(8'hf0, 8'h00, 1'b0, acks);
      chk_acks("reset acks", 3'b110);
      rd(8'h00, 8'h10, 8'hf7, "status reset");
      chk_val("settings reset", 8'h00, {4'h0, cfg});
      rd(8'h08, 8'h00, 8'hff, "pointer reset");
      chk_val("aborts", 8'h01, 8'(aborts));
      $display("test reset done");
      bcc_i2c_host_inst.read1(v, ra);
      chk_val("read address ack", 8'h01, {7'h0, ra});
      chk_val("status level high", 8'h18, v);
      @(posedge clk_sys);
      line_level_in <= 1'b0;
      bcc_i2c_host_inst.read1(v, ra);
      chk_val("status level low", 8'h10, v);
      $display("test level done");
      close_out();
   end
endmodule : bcc_bridge_ctrl_bench

`default_nettype wire
